// file: design/pmx_pkg.sv
// pmx_pkg: register map, reset values, route fields and carrier types
// for the port A..D pin function multiplexer.
// assumes one 200 MHz clock and a synchronous active-high reset.
package pmx_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DATA_A = 8'h00;
  localparam logic [7:0] OFS_DIR_A  = 8'h04;
  localparam logic [7:0] OFS_DATA_B = 8'h08;
  localparam logic [7:0] OFS_DIR_B  = 8'h0C;
  localparam logic [7:0] OFS_DATA_C = 8'h10;
  localparam logic [7:0] OFS_DIR_C  = 8'h14;
  localparam logic [7:0] OFS_DATA_D = 8'h18;
  localparam logic [7:0] OFS_DIR_D  = 8'h1C;
  localparam logic [7:0] OFS_ROUTE  = 8'h20;
  localparam logic [7:0] OFS_PINS   = 8'h24;
  localparam logic [7:0] OFS_GPSEL  = 8'h28;
  localparam logic [7:0] OFS_MODE   = 8'h2C;

  // ----------------------------------------------------------------
  // reset values: every port pin comes up as a general-purpose input
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_DATA   = 8'h00;
  localparam logic [7:0]  RST_DIR    = 8'h00;
  localparam logic [7:0]  RST_ROUTE  = 8'h00;
  localparam logic [7:0]  RST_OE_N   = 8'hFF;
  localparam logic        RST_IDLE   = 1'b1;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // ----------------------------------------------------------------
  // route register field positions
  // ----------------------------------------------------------------
  localparam int          RT_PWM6    = 0;
  localparam int          RT_PWM4    = 1;
  localparam int          RT_PWM2    = 2;
  localparam int          RT_TWI     = 3;
  localparam int          RT_CAN     = 4;
  localparam int          RT_LIN_LSB = 5;
  localparam logic [2:0]  LIN_PIN_CODE = 3'h1;

  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } pmx_pad_t;

  typedef struct packed {
    logic [15:0] fp_en;
    logic [15:0] fp;
    logic [3:0]  bp_en;
    logic [3:0]  bp;
  } pmx_lcd_t;

  // timer 0 channels 7..4 sit at index 3..0
  typedef struct packed {
    logic [3:0] en;
    logic [3:0] dout;
  } pmx_tim_t;

  typedef struct packed {
    logic amp_en;
    logic amp;
    logic tone_en;
    logic tone;
  } pmx_snd_t;

  typedef struct packed {
    logic tx_en;
    logic tx;
    logic rx_en;
  } pmx_ser_t;

  // open-drain pull requests from the two-wire controller
  typedef struct packed {
    logic sda_low;
    logic scl_low;
  } pmx_twi_t;

endpackage

// file: design/pmx_sync.sv
// pmx_sync: two flip-flop synchroniser for a bus of independent levels.
// assumes each bit is a slow level; no multi-bit coherence is promised.
`timescale 1ns/1ps
module pmx_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  import pmx_pkg::*;

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  if (W < 1) begin : g_chk
    $error("pmx_sync: W must be at least 1");
  end

  // no reset: the chain must keep sampling while reset is held
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_reg    <= meta_reg;
  end

  assign q_o = q_reg;
endmodule

// file: design/pmx_prio.sv
// pmx_prio: per-pin three-level function pick for one port.
// assumes enables are same-clock levels; result is registered by the caller.
`timescale 1ns/1ps
module pmx_prio #(
  parameter int W = 8
) (
  input  wire logic [W-1:0] hi_en_i,
  input  wire logic [W-1:0] hi_out_i,
  input  wire logic [W-1:0] hi_drv_i,
  input  wire logic [W-1:0] mid_en_i,
  input  wire logic [W-1:0] mid_out_i,
  input  wire logic [W-1:0] mid_drv_i,
  input  wire logic [W-1:0] gp_dout_i,
  input  wire logic [W-1:0] gp_dir_i,
  output logic      [W-1:0] pad_out_o,
  output logic      [W-1:0] pad_oe_n_o,
  output logic      [W-1:0] gp_sel_o
);
  import pmx_pkg::*;

  if (W < 1 || W > 8) begin : g_chk
    $error("pmx_prio: W must be 1 to 8");
  end

  // highest enabled function owns the pad; a claim with drv low
  // makes the pin an input for that function
  always_comb begin
    pad_out_o  = '0;
    pad_oe_n_o = '1;
    gp_sel_o   = '0;
    for (int i = 0; i < W; i++) begin
      if (hi_en_i[i]) begin
        pad_out_o[i]  = hi_out_i[i];
        pad_oe_n_o[i] = ~hi_drv_i[i];
      end else if (mid_en_i[i]) begin
        pad_out_o[i]  = mid_out_i[i];
        pad_oe_n_o[i] = ~mid_drv_i[i];
      end else begin
        pad_out_o[i]  = gp_dout_i[i];
        pad_oe_n_o[i] = ~gp_dir_i[i];
        gp_sel_o[i]   = 1'b1;
      end
    end
  end
endmodule

// file: design/pmx_port_mux.sv
// pmx_port_mux: pin function multiplexer for the debug pin and ports
// A, B, C and D, with a classic Wishbone register slave.
// assumes peripheral signals are on clk_i; pads are asynchronous.
//
// Function
// - highest-ranked enabled function owns the pad
// - debug pin is mode strap in reset
// - port A carries frontplane 7..0 at top
// - routed pwm 6,4,2 on A7,A6,A5
// - pwm 0 on A4 via pwm6 route
// - routed two-wire data, clock on A3,A2
// - A1, A0 offer only frontplane then gpio
// - port B carries backplane 3..0, gpio reset
// - C7 serial transmit, C6 serial receive
// - C5,C4 timer 7,6 then sound outputs
// - C3 timer 5 then LIN transmit
// - C2 timer 4 then LIN receive
// - C1,C0 CAN transmit, receive when routed
// - port D carries frontplane 15..8, gpio reset
// - port C leaves reset as gpio
`timescale 1ns/1ps
module pmx_port_mux (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // peripheral sources
  input  wire pmx_pkg::pmx_lcd_t lcd_i,
  input  wire logic [7:0]        pwm_i,
  input  wire pmx_pkg::pmx_tim_t timer0_chan_out_i,
  input  wire pmx_pkg::pmx_snd_t sound_i,
  input  wire pmx_pkg::pmx_ser_t serial1_i,
  input  wire pmx_pkg::pmx_twi_t twowire_i,
  input  wire logic              can_tx_i,
  input  wire logic              lin_xcvr_rx_i,
  input  wire logic              debug_out_i,
  input  wire logic              debug_drive_i,
  // peripheral returns
  output logic                   serial1_rx_o,
  output logic                   can_rx_o,
  output logic                   lin_xcvr_tx_o,
  output logic                   twowire_sda_o,
  output logic                   twowire_scl_o,
  output logic                   debug_rx_o,
  output logic                   boot_mode_select_o,
  // pads
  input  wire logic              debug_pin_i,
  output logic                   debug_pin_o,
  output logic                   debug_pin_oe_n_o,
  input  wire logic [7:0]        pad_a_i,
  output pmx_pkg::pmx_pad_t      pad_a_o,
  input  wire logic [3:0]        pad_b_i,
  output logic      [3:0]        pad_b_dout_o,
  output logic      [3:0]        pad_b_oe_n_o,
  input  wire logic [7:0]        pad_c_i,
  output pmx_pkg::pmx_pad_t      pad_c_o,
  input  wire logic [7:0]        pad_d_i,
  output pmx_pkg::pmx_pad_t      pad_d_o
);
  import pmx_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]  data_a_reg, data_a_next, dir_a_reg, dir_a_next;
  logic [7:0]  data_b_reg, data_b_next, dir_b_reg, dir_b_next;
  logic [7:0]  data_c_reg, data_c_next, dir_c_reg, dir_c_next;
  logic [7:0]  data_d_reg, data_d_next, dir_d_reg, dir_d_next;
  logic [7:0]  route_reg, route_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic        req;
  logic        wr_lo;
  logic [7:0]  sa, sc, sd;
  logic [3:0]  sb;
  logic        sdbg;
  logic        pwm6_route_bit, pwm4_route_bit, pwm2_route_bit;
  logic        twowire_route_bit, can_route_bit, lin_on;
  logic [2:0]  lin_route_field;
  logic [7:0]  a_mid_en, a_mid_out, a_mid_drv;
  logic [7:0]  c_hi_en, c_hi_out, c_hi_drv;
  logic [7:0]  c_mid_en, c_mid_out, c_mid_drv;
  logic [7:0]  a_out, a_oe_n, a_gp, c_out, c_oe_n, c_gp;
  logic [7:0]  d_out, d_oe_n, d_gp;
  logic [3:0]  b_out, b_oe_n, b_gp;
  pmx_pad_t    pa_reg, pa_next, pc_reg, pc_next, pd_reg, pd_next;
  logic [3:0]  pb_out_reg, pb_out_next, pb_oe_reg, pb_oe_next;
  logic        dbg_o_reg, dbg_o_next, dbg_oe_reg, dbg_oe_next;
  logic        boot_reg, boot_next;
  logic        ser_rx_reg, ser_rx_next, can_rx_reg, can_rx_next;
  logic        lin_tx_reg, lin_tx_next, dbg_rx_reg, dbg_rx_next;
  logic        sda_reg, sda_next, scl_reg, scl_next;

  // address match on the word part only
  function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
    return a[7:2] == o[7:2];
  endfunction

  // low-byte write merge, the only lane that holds register bits
  function automatic logic [7:0] merge(input logic [7:0] cur,
                                       input logic       en,
                                       input logic [7:0] d);
    return en ? d : cur;
  endfunction

  // ----------------------------------------------------------------
  // pad input synchronisers
  // ----------------------------------------------------------------
  pmx_sync #(.W(8)) u_sync_a (
    .clk_i (clk_i),
    .d_i   (pad_a_i),
    .q_o   (sa)
  );
  pmx_sync #(.W(4)) u_sync_b (
    .clk_i (clk_i),
    .d_i   (pad_b_i),
    .q_o   (sb)
  );
  pmx_sync #(.W(8)) u_sync_c (
    .clk_i (clk_i),
    .d_i   (pad_c_i),
    .q_o   (sc)
  );
  pmx_sync #(.W(8)) u_sync_d (
    .clk_i (clk_i),
    .d_i   (pad_d_i),
    .q_o   (sd)
  );
  pmx_sync #(.W(1)) u_sync_dbg (
    .clk_i (clk_i),
    .d_i   (debug_pin_i),
    .q_o   (sdbg)
  );

  // ----------------------------------------------------------------
  // wishbone register file
  // ----------------------------------------------------------------
  // one request is served per ack; the cycle after ack is a gap
  assign req   = wb_cyc_i & wb_stb_i & ~ack_reg;
  // write lands on the edge where the master sees ack, request still held
  assign wr_lo = wb_cyc_i & wb_stb_i & ack_reg & wb_we_i & wb_sel_i[0];

  // write decode; unmapped writes are acked and dropped
  always_comb begin
    ack_next    = req;
    data_a_next = merge(data_a_reg, wr_lo & hit(wb_adr_i, OFS_DATA_A), wb_dat_i[7:0]);
    dir_a_next  = merge(dir_a_reg,  wr_lo & hit(wb_adr_i, OFS_DIR_A),  wb_dat_i[7:0]);
    data_b_next = merge(data_b_reg, wr_lo & hit(wb_adr_i, OFS_DATA_B), wb_dat_i[7:0]);
    dir_b_next  = merge(dir_b_reg,  wr_lo & hit(wb_adr_i, OFS_DIR_B),  wb_dat_i[7:0]);
    data_c_next = merge(data_c_reg, wr_lo & hit(wb_adr_i, OFS_DATA_C), wb_dat_i[7:0]);
    dir_c_next  = merge(dir_c_reg,  wr_lo & hit(wb_adr_i, OFS_DIR_C),  wb_dat_i[7:0]);
    data_d_next = merge(data_d_reg, wr_lo & hit(wb_adr_i, OFS_DATA_D), wb_dat_i[7:0]);
    dir_d_next  = merge(dir_d_reg,  wr_lo & hit(wb_adr_i, OFS_DIR_D),  wb_dat_i[7:0]);
    route_next  = merge(route_reg,  wr_lo & hit(wb_adr_i, OFS_ROUTE),  wb_dat_i[7:0]);
    // port B has four pins; upper bits stay zero
    data_b_next[7:4] = 4'h0;
    dir_b_next[7:4]  = 4'h0;
  end

  // read mux, registered so data lines up with ack
  always_comb begin
    rdat_next = rdat_reg;
    if (req) begin
      unique case (wb_adr_i[7:2])
        OFS_DATA_A[7:2]: rdat_next = {24'h0, data_a_reg};
        OFS_DIR_A[7:2]:  rdat_next = {24'h0, dir_a_reg};
        OFS_DATA_B[7:2]: rdat_next = {24'h0, data_b_reg};
        OFS_DIR_B[7:2]:  rdat_next = {24'h0, dir_b_reg};
        OFS_DATA_C[7:2]: rdat_next = {24'h0, data_c_reg};
        OFS_DIR_C[7:2]:  rdat_next = {24'h0, dir_c_reg};
        OFS_DATA_D[7:2]: rdat_next = {24'h0, data_d_reg};
        OFS_DIR_D[7:2]:  rdat_next = {24'h0, dir_d_reg};
        OFS_ROUTE[7:2]:  rdat_next = {24'h0, route_reg};
        OFS_PINS[7:2]:   rdat_next = {4'h0, sd, sc, sb, sa};
        OFS_GPSEL[7:2]:  rdat_next = {4'h0, d_gp, c_gp, b_gp, a_gp};
        OFS_MODE[7:2]:   rdat_next = {31'h0, boot_reg};
        default:         rdat_next = RD_UNMAPPED;
      endcase
    end
  end

  // register stage for the bus and port registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg    <= 1'b0;
      rdat_reg   <= RD_UNMAPPED;
      data_a_reg <= RST_DATA;
      dir_a_reg  <= RST_DIR;
      data_b_reg <= RST_DATA;
      dir_b_reg  <= RST_DIR;
      data_c_reg <= RST_DATA;
      dir_c_reg  <= RST_DIR;
      data_d_reg <= RST_DATA;
      dir_d_reg  <= RST_DIR;
      route_reg  <= RST_ROUTE;
    end else begin
      ack_reg    <= ack_next;
      rdat_reg   <= rdat_next;
      data_a_reg <= data_a_next;
      dir_a_reg  <= dir_a_next;
      data_b_reg <= data_b_next;
      dir_b_reg  <= dir_b_next;
      data_c_reg <= data_c_next;
      dir_c_reg  <= dir_c_next;
      data_d_reg <= data_d_next;
      dir_d_reg  <= dir_d_next;
      route_reg  <= route_next;
    end
  end

  // ----------------------------------------------------------------
  // route fields
  // ----------------------------------------------------------------
  // one bit moves both pwm 6 and pwm 0; they cannot be split
  assign pwm6_route_bit    = route_reg[RT_PWM6];
  assign pwm4_route_bit    = route_reg[RT_PWM4];
  assign pwm2_route_bit    = route_reg[RT_PWM2];
  assign twowire_route_bit = route_reg[RT_TWI];
  assign can_route_bit     = route_reg[RT_CAN];
  assign lin_route_field   = route_reg[RT_LIN_LSB +: 3];
  assign lin_on            = lin_route_field == LIN_PIN_CODE;

  // ----------------------------------------------------------------
  // per-pin function tables
  // ----------------------------------------------------------------
  // port A middle rank: pwm and open-drain two-wire
  always_comb begin
    a_mid_en  = {pwm6_route_bit, pwm4_route_bit, pwm2_route_bit,
                 pwm6_route_bit,
                 twowire_route_bit, twowire_route_bit,
                 2'b00};
    a_mid_out = {pwm_i[6], pwm_i[4], pwm_i[2], pwm_i[0],
                 2'b00, 2'b00};
    // two-wire only ever pulls low, otherwise the pin is an input
    a_mid_drv = {4'hF, twowire_i.sda_low, twowire_i.scl_low, 2'b00};
  end

  // port C top rank: serial, timer, can
  always_comb begin
    c_hi_en  = {serial1_i.tx_en, serial1_i.rx_en,
                timer0_chan_out_i.en,
                can_route_bit, can_route_bit};
    c_hi_out = {serial1_i.tx, 1'b0, timer0_chan_out_i.dout,
                can_tx_i, 1'b0};
    c_hi_drv = {1'b1, 1'b0, 4'hF, 1'b1, 1'b0};
  end

  // port C middle rank: sound then LIN transceiver
  always_comb begin
    c_mid_en  = {2'b00, sound_i.amp_en, sound_i.tone_en,
                 lin_on, lin_on, 2'b00};
    c_mid_out = {2'b00, sound_i.amp, sound_i.tone,
                 1'b0, lin_xcvr_rx_i, 2'b00};
    c_mid_drv = {2'b00, 2'b11, 1'b0, 1'b1, 2'b00};
  end

  // ----------------------------------------------------------------
  // priority pickers
  // ----------------------------------------------------------------
  pmx_prio #(.W(8)) u_prio_a (
    .hi_en_i    (lcd_i.fp_en[7:0]),
    .hi_out_i   (lcd_i.fp[7:0]),
    .hi_drv_i   (8'hFF),
    .mid_en_i   (a_mid_en),
    .mid_out_i  (a_mid_out),
    .mid_drv_i  (a_mid_drv),
    .gp_dout_i  (data_a_reg),
    .gp_dir_i   (dir_a_reg),
    .pad_out_o  (a_out),
    .pad_oe_n_o (a_oe_n),
    .gp_sel_o   (a_gp)
  );
  pmx_prio #(.W(4)) u_prio_b (
    .hi_en_i    (lcd_i.bp_en),
    .hi_out_i   (lcd_i.bp),
    .hi_drv_i   (4'hF),
    .mid_en_i   (4'h0),
    .mid_out_i  (4'h0),
    .mid_drv_i  (4'h0),
    .gp_dout_i  (data_b_reg[3:0]),
    .gp_dir_i   (dir_b_reg[3:0]),
    .pad_out_o  (b_out),
    .pad_oe_n_o (b_oe_n),
    .gp_sel_o   (b_gp)
  );
  pmx_prio #(.W(8)) u_prio_c (
    .hi_en_i    (c_hi_en),
    .hi_out_i   (c_hi_out),
    .hi_drv_i   (c_hi_drv),
    .mid_en_i   (c_mid_en),
    .mid_out_i  (c_mid_out),
    .mid_drv_i  (c_mid_drv),
    .gp_dout_i  (data_c_reg),
    .gp_dir_i   (dir_c_reg),
    .pad_out_o  (c_out),
    .pad_oe_n_o (c_oe_n),
    .gp_sel_o   (c_gp)
  );
  pmx_prio #(.W(8)) u_prio_d (
    .hi_en_i    (lcd_i.fp_en[15:8]),
    .hi_out_i   (lcd_i.fp[15:8]),
    .hi_drv_i   (8'hFF),
    .mid_en_i   (8'h00),
    .mid_out_i  (8'h00),
    .mid_drv_i  (8'h00),
    .gp_dout_i  (data_d_reg),
    .gp_dir_i   (dir_d_reg),
    .pad_out_o  (d_out),
    .pad_oe_n_o (d_oe_n),
    .gp_sel_o   (d_gp)
  );

  // ----------------------------------------------------------------
  // pad and return stage
  // ----------------------------------------------------------------
  // inputs to peripherals idle high when their pin is not claimed; debug receive follows the debug pin outside reset
  always_comb begin
    pa_next      = '{dout: a_out, oe_n: a_oe_n};
    pb_out_next  = b_out;
    pb_oe_next   = b_oe_n;
    pc_next      = '{dout: c_out, oe_n: c_oe_n};
    pd_next      = '{dout: d_out, oe_n: d_oe_n};
    ser_rx_next  = (c_hi_en[6]) ? sc[6] : RST_IDLE;
    can_rx_next  = (can_route_bit) ? sc[0] : RST_IDLE;
    lin_tx_next  = (~c_hi_en[3] & lin_on) ? sc[3] : RST_IDLE;
    sda_next     = (~lcd_i.fp_en[3] & twowire_route_bit) ? sa[3] : RST_IDLE;
    scl_next     = (~lcd_i.fp_en[2] & twowire_route_bit) ? sa[2] : RST_IDLE;
    dbg_rx_next  = sdbg;
    dbg_o_next   = debug_out_i;
    dbg_oe_next  = ~debug_drive_i;
    boot_next    = boot_reg;
  end

  // strap capture runs in reset; pads fall back to gpio inputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pa_reg     <= '{dout: RST_DATA, oe_n: RST_OE_N};
      pb_out_reg <= RST_DATA[3:0];
      pb_oe_reg  <= RST_OE_N[3:0];
      pc_reg     <= '{dout: RST_DATA, oe_n: RST_OE_N};
      pd_reg     <= '{dout: RST_DATA, oe_n: RST_OE_N};
      ser_rx_reg <= RST_IDLE;
      can_rx_reg <= RST_IDLE;
      lin_tx_reg <= RST_IDLE;
      sda_reg    <= RST_IDLE;
      scl_reg    <= RST_IDLE;
      dbg_rx_reg <= RST_IDLE;
      dbg_o_reg  <= 1'b0;
      dbg_oe_reg <= 1'b1;
      boot_reg   <= sdbg;
    end else begin
      pa_reg     <= pa_next;
      pb_out_reg <= pb_out_next;
      pb_oe_reg  <= pb_oe_next;
      pc_reg     <= pc_next;
      pd_reg     <= pd_next;
      ser_rx_reg <= ser_rx_next;
      can_rx_reg <= can_rx_next;
      lin_tx_reg <= lin_tx_next;
      sda_reg    <= sda_next;
      scl_reg    <= scl_next;
      dbg_rx_reg <= dbg_rx_next;
      dbg_o_reg  <= dbg_o_next;
      dbg_oe_reg <= dbg_oe_next;
      boot_reg   <= boot_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o           = ack_reg;
  assign wb_dat_o           = rdat_reg;
  assign pad_a_o            = pa_reg;
  assign pad_b_dout_o       = pb_out_reg;
  assign pad_b_oe_n_o       = pb_oe_reg;
  assign pad_c_o            = pc_reg;
  assign pad_d_o            = pd_reg;
  assign serial1_rx_o       = ser_rx_reg;
  assign can_rx_o           = can_rx_reg;
  assign lin_xcvr_tx_o      = lin_tx_reg;
  assign twowire_sda_o      = sda_reg;
  assign twowire_scl_o      = scl_reg;
  assign debug_rx_o         = dbg_rx_reg;
  assign debug_pin_o        = dbg_o_reg;
  assign debug_pin_oe_n_o   = dbg_oe_reg;
  assign boot_mode_select_o = boot_reg;
endmodule

// file: verif/pmx_pins_model.sv
// pmx_pins_model: board pins around the mux, each port pin with a pull-up.
// assumes pad outputs are active-low enables; strap level set by the bench.
// a far-side driver may hold released port C pins low.
`timescale 1ns/1ps
module pmx_pins_model (
  input  wire pmx_pkg::pmx_pad_t pad_a_o,
  input  wire pmx_pkg::pmx_pad_t pad_c_o,
  input  wire pmx_pkg::pmx_pad_t pad_d_o,
  input  wire logic [3:0]        pad_b_dout_o,
  input  wire logic [3:0]        pad_b_oe_n_o,
  input  wire logic              debug_pin_o,
  input  wire logic              debug_pin_oe_n_o,
  input  wire logic [7:0]        c_ext_low,
  input  wire logic              strap_lvl,
  output logic      [7:0]        pad_a_i,
  output logic      [3:0]        pad_b_i,
  output logic      [7:0]        pad_c_i,
  output logic      [7:0]        pad_d_i,
  output logic                   debug_pin_i
);
  // ----------------------------------------------------------------
  // wire levels
  // ----------------------------------------------------------------
  // a released port pin floats up unless c_ext_low holds it low, so a stale driven value never lingers
  assign pad_a_i = (pad_a_o.dout & ~pad_a_o.oe_n) | pad_a_o.oe_n;
  assign pad_b_i = (pad_b_dout_o & ~pad_b_oe_n_o) | pad_b_oe_n_o;
  assign pad_c_i = (pad_c_o.dout & ~pad_c_o.oe_n) | (pad_c_o.oe_n & ~c_ext_low);
  assign pad_d_i = (pad_d_o.dout & ~pad_d_o.oe_n) | pad_d_o.oe_n;
  assign debug_pin_i = debug_pin_oe_n_o ? strap_lvl : debug_pin_o; // strap when idle
endmodule

// file: verif/pmx_port_mux_chk.sv
// pmx_port_mux_chk: pad priority checks on the mux top ports.
// assumes pad outputs follow enables one clock later.
`timescale 1ns/1ps
module pmx_port_mux_chk (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire pmx_pkg::pmx_lcd_t lcd_i,
  input  wire pmx_pkg::pmx_tim_t timer0_chan_out_i,
  input  wire pmx_pkg::pmx_snd_t sound_i,
  input  wire pmx_pkg::pmx_ser_t serial1_i,
  input  wire logic              debug_out_i,
  input  wire logic              debug_drive_i,
  input  wire logic              debug_pin_o,
  input  wire logic              debug_pin_oe_n_o,
  input  wire pmx_pkg::pmx_pad_t pad_a_o,
  input  wire logic [3:0]        pad_b_dout_o,
  input  wire logic [3:0]        pad_b_oe_n_o,
  input  wire pmx_pkg::pmx_pad_t pad_c_o,
  input  wire pmx_pkg::pmx_pad_t pad_d_o
);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  reset_gpio_a: assert property ($fell(rst_i) |-> pad_c_o.oe_n == 8'hFF
    && debug_pin_oe_n_o
    && pad_a_o.oe_n == 8'hFF && pad_d_o.oe_n == 8'hFF && pad_b_oe_n_o == 4'hF)
    else $error("pins not released after reset");
  fp_port_a_a: assert property (lcd_i.fp_en[7] |=> !pad_a_o.oe_n[7]
    && pad_a_o.dout[7] == $past(lcd_i.fp[7])) else $error("frontplane 7 lost");
  fp_port_d_a: assert property (lcd_i.fp_en[15] |=> !pad_d_o.oe_n[7]
    && pad_d_o.dout[7] == $past(lcd_i.fp[15])) else $error("frontplane 15 lost");
  bp_port_b_a: assert property (lcd_i.bp_en[0] |=> !pad_b_oe_n_o[0]
    && pad_b_dout_o[0] == $past(lcd_i.bp[0])) else $error("backplane 0 lost");
  timer_c5_a: assert property (timer0_chan_out_i.en[3] |=> !pad_c_o.oe_n[5]
    && pad_c_o.dout[5] == $past(timer0_chan_out_i.dout[3])) else $error("timer 7 lost");
  sound_c5_a: assert property (!timer0_chan_out_i.en[3] && sound_i.amp_en |=>
    !pad_c_o.oe_n[5] && pad_c_o.dout[5] == $past(sound_i.amp)) else $error("amplitude lost");
  tone_under_a: assert property (timer0_chan_out_i.en[2] && sound_i.tone_en |=>
    pad_c_o.dout[4] == $past(timer0_chan_out_i.dout[2])) else $error("tone beat timer 6");
  serial_tx_a: assert property (serial1_i.tx_en |=> !pad_c_o.oe_n[7]
    && pad_c_o.dout[7] == $past(serial1_i.tx)) else $error("serial transmit lost");
  debug_drive_a: assert property (debug_drive_i |=> !debug_pin_oe_n_o
    && debug_pin_o == $past(debug_out_i)) else $error("debug pin not driven");
  // main scenarios seen
  lcd_c: cover property (lcd_i.fp_en[7] && lcd_i.fp_en[15]);
  timer_c: cover property (timer0_chan_out_i.en[3] && sound_i.amp_en);
  debug_c: cover property (debug_drive_i);
endmodule

bind pmx_port_mux pmx_port_mux_chk u_pmx_port_mux_chk (.*);

// file: verif/pmx_port_mux_bench.sv
// pmx_port_mux_bench: register and pad sequences with expected values.
// assumes the pins model closes each pad loop through pull-ups.
`timescale 1ns/1ps
module pmx_port_mux_bench;
  import pmx_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
  logic [7:0]  wb_adr_i = '0, pwm_i = '0, pad_a_i, pad_c_i, pad_d_i, c_ext_low = '0;
  logic [3:0]  wb_sel_i = 4'hF, pad_b_i, pad_b_dout_o, pad_b_oe_n_o;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  pmx_lcd_t    lcd_i = '0;
  pmx_tim_t    timer0_chan_out_i = '0;
  pmx_snd_t    sound_i = '0;
  pmx_ser_t    serial1_i = '0;
  pmx_twi_t    twowire_i = '0;
  pmx_pad_t    pad_a_o, pad_c_o, pad_d_o;
  logic can_tx_i = 0, lin_xcvr_rx_i = 0, debug_out_i = 0, debug_drive_i = 0, strap_lvl = 1;
  logic serial1_rx_o, can_rx_o, lin_xcvr_tx_o, twowire_sda_o, twowire_scl_o;
  logic debug_rx_o, boot_mode_select_o, debug_pin_i, debug_pin_o, debug_pin_oe_n_o;
  int   fail_count = 0, n_checks = 0;
  pmx_port_mux u_pmx_port_mux (.*);
  pmx_pins_model u_pmx_pins_model (.*);
  // 200 MHz clock
  always #2.5 clk_i = ~clk_i;
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one classic cycle; a dead slave is caught by the watchdog
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask
  // driven bits of port C compared under the enable mask
  task automatic port_c(input logic [7:0] oe_n, input logic [7:0] dout);
    repeat (2) @(posedge clk_i);
    chk("c_oe_n", {24'h0, oe_n}, {24'h0, pad_c_o.oe_n});
    chk("c_dout", {24'h0, dout}, {24'h0, pad_c_o.dout & ~oe_n});
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    wb(0, OFS_MODE, 0); chk("mode", 32'h1, rd);
    wb(0, OFS_GPSEL, 0); chk("gpsel", 32'h0FFF_FFFF, rd);
    wb(0, 8'h30, 0); chk("unmapped", RD_UNMAPPED, rd);
    wb(1, OFS_DIR_A, 32'hFF);
    wb(1, OFS_DATA_A, 32'hA5);
    repeat (5) @(posedge clk_i);
    chk("pad_a", {16'h0, 8'hA5, 8'h00}, pad_a_o);
    wb(0, OFS_PINS, 0); chk("pins_a", 32'hA5, rd & 32'hFF);
    lcd_i <= '{fp_en: 16'hFFFF, fp: 16'h5A3C, bp_en: 4'hF, bp: 4'hA};
    repeat (2) @(posedge clk_i);
    chk("pad_a_lcd", {16'h0, 8'h3C, 8'h00}, pad_a_o);
    chk("pad_d_lcd", {16'h0, 8'h5A, 8'h00}, pad_d_o);
    chk("pad_b_lcd", {24'h0, 4'hA, 4'h0}, {pad_b_dout_o, pad_b_oe_n_o});
    lcd_i <= '0;
    pwm_i <= 8'h55;
    twowire_i <= 2'b10;
    wb(1, OFS_DATA_A, 32'h00);
    wb(1, OFS_ROUTE, 32'h0F);
    repeat (5) @(posedge clk_i);
    chk("a_oe_n", 32'h04, pad_a_o.oe_n);
    chk("a_dout", 32'hF0, pad_a_o.dout & 8'hFB);
    chk("twi_ret", 32'h1, {twowire_sda_o, twowire_scl_o});
    wb(0, OFS_GPSEL, 0); chk("gpsel_a", 32'h03, rd & 32'hFF);
    wb(1, OFS_ROUTE, 32'h30);
    serial1_i <= 3'b111;
    sound_i <= 4'b1110;
    // far side pulls the claimed input pins low
    c_ext_low <= 8'h49;
    port_c(8'h49, 8'hA0);
    timer0_chan_out_i <= 8'hF5;
    port_c(8'h41, 8'h94);
    chk("returns", 32'h1, {serial1_rx_o, can_rx_o, lin_xcvr_tx_o});
    debug_out_i <= 1;
    debug_drive_i <= 1;
    repeat (2) @(posedge clk_i);
    chk("debug", 32'h2, {debug_pin_o, debug_pin_oe_n_o});
    // pin now low, strap must keep its reset capture
    debug_out_i <= 0;
    repeat (5) @(posedge clk_i);
    chk("debug_rx", 32'h1, {debug_rx_o, boot_mode_select_o});
    end_of_test();
  end
  // watchdog well past the fewer than one hundred cycles the sequence needs
  initial begin
    #20000;
    fail_count++;
    end_of_test();
  end
endmodule
